// ---- common/ts_map.vh ----
// Register offsets, field positions, reset values and timing counts of the sensor.
`ifndef TS_MAP_VH
`define TS_MAP_VH

// Register selector codes held in the two low selector bits.
`define TS_SEL_RESULT 2'b00
`define TS_SEL_CONFIG 2'b01
`define TS_SEL_UPPER 2'b10
`define TS_SEL_LOWER 2'b11

// Operating configuration field positions.
`define TS_CFG_POWER_DOWN 7
`define TS_CFG_FILTER_ON 6
`define TS_CFG_OVER_DISABLE 5
`define TS_CFG_OVER_POLARITY 4

// Reset values.
`define TS_CONFIG_RESET 8'h40
`define TS_SELECTOR_RESET 8'h00
`define TS_LIMIT_RESET 8'h00
`define TS_RESULT_RESET 10'h000

// Second result byte flag positions.
`define TS_FLAG_OVER 5
`define TS_FLAG_UPPER 4
`define TS_FLAG_LOWER 3

// Serial bus address of this slave.
`define TS_BUS_ADDR 7'h48

// Extended grade decode offsets, in quarter degrees.
`define TS_EXT_OFFSET_POS 12'h064
`define TS_EXT_OFFSET_NEG 12'h19C

// Timing: clock rate, countdown, conversion and glitch filter times.
`define TS_CLK_MHZ 50
`define TS_WAIT_US 400
`define TS_CONV_US 25
`define TS_FILT_NS 50
`define TS_WAIT_CYC (`TS_WAIT_US * `TS_CLK_MHZ)
`define TS_CONV_CYC (`TS_CONV_US * `TS_CLK_MHZ)
`define TS_FILT_CYC ((`TS_FILT_NS * `TS_CLK_MHZ + 999) / 1000)

`endif

// ---- hdl/ts_pin_sync.v ----
// Three-stage pin synchroniser with an optional glitch filter.
`timescale 1ns/1ps
module ts_pin_sync
#(
    parameter FILT_CYC = 3
)
(
    input wire clk,
    input wire rst,
    input wire pin,
    input wire filter_on,
    output reg level
);

    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    reg [7:0] stable_reg;

    // The first stage feeds only the second; a change counts once stages two and three agree.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
        end
        else
        begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // With the filter on, a new level must hold for FILT_CYC cycles before it is taken.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stable_reg <= 8'h00;
            level <= 1'b1;
        end
        else if (s2_reg == s3_reg && s3_reg != level)
        begin
            if (!filter_on || stable_reg >= FILT_CYC[7:0])
            begin
                level <= s3_reg;
                stable_reg <= 8'h00;
            end
            else
            begin
                stable_reg <= stable_reg + 8'h01;
            end
        end
        else
        begin
            stable_reg <= 8'h00;
        end
    end

endmodule // ts_pin_sync

// ---- hdl/ts_sensor_regs.v ----
// Register file, result formatting, limit logic and two-wire slave of the temperature sensor.
//
// Operation
// RULE1 - Result is 10-bit two's complement, quarter degrees.
// RULE2 - Eight-bit selector; only low two bits select.
// RULE3 - First written byte sets selector; later bytes follow.
// RULE4 - 00 result, 01 config, 10 upper, 11 lower.
// RULE5 - Config bit 7 set powers down conversions.
// RULE6 - Config bit 6 clear bypasses bus filtering.
// RULE7 - Config bit 5 set disables over-limit output.
// RULE8 - Config bit 4 sets over-limit output polarity.
// RULE9 - Master writes zeros to config bits 3-0.
// RULE10 - Config resets to filter on, all else zero.
// RULE11 - Result read as high byte then low byte.
// RULE12 - Second byte: flags at 5-3, zeros at 2-0.
// RULE13 - Over-limit flag mirrors the over-limit pin.
// RULE14 - Upper flag sets above limit, clears on read.
// RULE15 - Lower flag sets below limit, clears on read.
// RULE16 - Extended grade code decodes with 25 degree offset.
// RULE17 - Standard grade code decodes as signed quarters.
// RULE18 - Upper flag bit 4, lower flag bit 3.
// RULE19 - Convert after each 400 us countdown, 25 us.
// RULE20 - Over-limit sets above upper, clears below lower.
// RULE21 - Selector persists across any number of reads.
// RULE22 - Limit and config writes carry one data byte.
`timescale 1ns/1ps
`include "ts_map.vh"
module ts_sensor_regs
#(
    parameter WAIT_CYC = `TS_WAIT_CYC,
    parameter CONV_CYC = `TS_CONV_CYC,
    parameter FILT_CYC = `TS_FILT_CYC,
    parameter EXT_GRADE = 0,
    parameter [6:0] BUS_ADDR = `TS_BUS_ADDR
)
(
    input wire clk,
    input wire rst,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe,
    output wire alert_out,
    output wire alert_oe,
    input wire [9:0] adc_code,
    output reg conv_hold,
    output reg [11:0] temp_quarters
);

    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_ACK_ADDR = 3'd2;
    localparam ST_WRITE = 3'd3;
    localparam ST_ACK_WRITE = 3'd4;
    localparam ST_READ = 3'd5;
    localparam ST_MASTER_ACK = 3'd6;

    // Registers seen by the master.
    reg [9:0] result_reg;
    reg [7:0] config_reg;
    reg [7:0] upper_reg;
    reg [7:0] lower_reg;
    reg [7:0] selector_reg;
    reg upper_flag_reg;
    reg lower_flag_reg;
    reg over_state_reg;

    // Conversion timebase.
    reg [31:0] tick_reg;
    reg busy_reg;
    reg done_reg;

    // Serial engine.
    reg [2:0] state_reg;
    reg [7:0] shift_reg;
    reg [3:0] bit_reg;
    reg [7:0] tx_reg;
    reg rw_reg;
    reg byte_idx_reg;
    reg second_half_reg;
    reg scl_q_reg;
    reg sda_q_reg;

    wire scl_s;
    wire sda_s;
    wire filter_on;
    wire scl_rise;
    wire scl_fall;
    wire bus_start;
    wire bus_stop;
    wire over_enabled;
    wire over_pin_level;
    wire [11:0] cur_quarters;
    wire above_upper;
    wire below_lower;
    wire [7:0] rd_byte;
    wire [1:0] sel;

    // Decodes a result code into signed quarter degrees for the chosen grade.
    function [11:0] ts_to_quarters;
        input [9:0] code;
        input ext;
        begin
            if (ext && !code[9])
                ts_to_quarters = {3'b000, code[8:0]} + `TS_EXT_OFFSET_POS; // RULE16
            else if (ext)
                ts_to_quarters = {3'b000, code[8:0]} - `TS_EXT_OFFSET_NEG; // RULE16
            else
                ts_to_quarters = {{2{code[9]}}, code}; // RULE17
        end
    endfunction

    // Scales a whole-degree limit into quarter degrees.
    function [11:0] ts_limit_quarters;
        input [7:0] lim;
        begin
            ts_limit_quarters = {{2{lim[7]}}, lim, 2'b00};
        end
    endfunction

    // Filtering follows the configuration bit; clearing it bypasses the filter.
    assign filter_on = config_reg[`TS_CFG_FILTER_ON]; // RULE6

    ts_pin_sync #(.FILT_CYC(FILT_CYC)) u_scl_sync
    (
        .clk(clk),
        .rst(rst),
        .pin(scl_in),
        .filter_on(filter_on),
        .level(scl_s)
    );

    ts_pin_sync #(.FILT_CYC(FILT_CYC)) u_sda_sync
    (
        .clk(clk),
        .rst(rst),
        .pin(sda_in),
        .filter_on(filter_on),
        .level(sda_s)
    );

    // Bus events derived from the settled line levels.
    assign scl_rise = scl_s && !scl_q_reg;
    assign scl_fall = !scl_s && scl_q_reg;
    assign bus_start = scl_s && scl_q_reg && sda_q_reg && !sda_s;
    assign bus_stop = scl_s && scl_q_reg && !sda_q_reg && sda_s;
    assign sel = selector_reg[1:0]; // RULE2

    // Limit comparison on the stored result.
    assign cur_quarters = ts_to_quarters(result_reg, EXT_GRADE != 0);
    assign above_upper = $signed(cur_quarters) > $signed(ts_limit_quarters(upper_reg));
    assign below_lower = $signed(cur_quarters) < $signed(ts_limit_quarters(lower_reg));

    // The pin is open drain: it is pulled low only when its level must be low.
    assign over_enabled = !config_reg[`TS_CFG_OVER_DISABLE]; // RULE7
    assign over_pin_level = (over_enabled && over_state_reg) ?
        config_reg[`TS_CFG_OVER_POLARITY] : !config_reg[`TS_CFG_OVER_POLARITY]; // RULE8
    assign alert_out = 1'b0;
    assign alert_oe = !over_pin_level;
    assign sda_out = 1'b0;

    // Byte to send next, chosen by the selector.
    assign rd_byte = (sel == `TS_SEL_RESULT && !second_half_reg) ? result_reg[9:2] : // RULE11
        (sel == `TS_SEL_RESULT) ? {result_reg[1:0], over_pin_level, // RULE13
        upper_flag_reg, lower_flag_reg, 3'b000} : // RULE12 RULE18
        (sel == `TS_SEL_CONFIG) ? config_reg :
        (sel == `TS_SEL_UPPER) ? upper_reg : lower_reg; // RULE4

    // Timebase: count down, hold for the conversion time, then load the result.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tick_reg <= 32'h0000_0000;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            conv_hold <= 1'b0;
            result_reg <= `TS_RESULT_RESET;
        end
        else if (config_reg[`TS_CFG_POWER_DOWN] && !busy_reg)
        begin
            // Power-down lets a running conversion finish, so no hold pulse is cut short,
            // then stops the timebase; the bus stays alive.
            tick_reg <= 32'h0000_0000; // RULE5
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            conv_hold <= 1'b0;
        end
        else if (!busy_reg)
        begin
            done_reg <= 1'b0;
            if (tick_reg >= WAIT_CYC - 1)
            begin
                tick_reg <= 32'h0000_0000; // RULE19
                busy_reg <= 1'b1;
                conv_hold <= 1'b1;
            end
            else
            begin
                tick_reg <= tick_reg + 32'h0000_0001;
            end
        end
        else if (tick_reg >= CONV_CYC - 1)
        begin
            tick_reg <= 32'h0000_0000;
            busy_reg <= 1'b0;
            conv_hold <= 1'b0;
            done_reg <= 1'b1;
            result_reg <= adc_code; // RULE1 RULE19
        end
        else
        begin
            tick_reg <= tick_reg + 32'h0000_0001;
        end
    end

    // Decoded temperature for the system, refreshed every cycle from the result.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            temp_quarters <= 12'h000;
        else
            temp_quarters <= cur_quarters; // RULE16 RULE17
    end

    // Over-limit state has hysteresis: set above upper, cleared only below lower.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            over_state_reg <= 1'b0;
        else if (done_reg && above_upper)
            over_state_reg <= 1'b1; // RULE20
        else if (done_reg && below_lower)
            over_state_reg <= 1'b0; // RULE20
    end

    // Limit flags: a new conversion that still breaks a limit sets the flag even
    // in the cycle the second result byte clears it, so no event is lost.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            upper_flag_reg <= 1'b0;
            lower_flag_reg <= 1'b0;
        end
        else
        begin
            if (done_reg && above_upper)
                upper_flag_reg <= 1'b1; // RULE14
            else if (state_reg == ST_MASTER_ACK && scl_rise && sel == `TS_SEL_RESULT &&
                     second_half_reg)
                upper_flag_reg <= 1'b0; // RULE14
            if (done_reg && below_lower)
                lower_flag_reg <= 1'b1; // RULE15
            else if (state_reg == ST_MASTER_ACK && scl_rise && sel == `TS_SEL_RESULT &&
                     second_half_reg)
                lower_flag_reg <= 1'b0; // RULE15
        end
    end

    // Previous settled levels for edge and condition detection.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end
        else
        begin
            scl_q_reg <= scl_s;
            sda_q_reg <= sda_s;
        end
    end

    // Two-wire slave: bits sampled on clock rise, data driven after clock fall.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            bit_reg <= 4'h0;
            tx_reg <= 8'h00;
            rw_reg <= 1'b0;
            byte_idx_reg <= 1'b0;
            second_half_reg <= 1'b0;
            sda_oe <= 1'b0;
            selector_reg <= `TS_SELECTOR_RESET;
            config_reg <= `TS_CONFIG_RESET; // RULE10
            upper_reg <= `TS_LIMIT_RESET;
            lower_reg <= `TS_LIMIT_RESET;
        end
        else if (bus_start)
        begin
            // A start, repeated or not, always begins a fresh address byte.
            state_reg <= ST_ADDR;
            bit_reg <= 4'h0;
            byte_idx_reg <= 1'b0;
            second_half_reg <= 1'b0;
            sda_oe <= 1'b0;
        end
        else if (bus_stop)
        begin
            state_reg <= ST_IDLE;
            sda_oe <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_ADDR:
                begin
                    if (scl_rise)
                    begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        bit_reg <= bit_reg + 4'h1;
                    end
                    else if (scl_fall && bit_reg == 4'h8)
                    begin
                        if (shift_reg[7:1] == BUS_ADDR)
                        begin
                            rw_reg <= shift_reg[0];
                            sda_oe <= 1'b1;
                            state_reg <= ST_ACK_ADDR;
                        end
                        else
                        begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_ACK_ADDR:
                begin
                    if (scl_fall)
                    begin
                        bit_reg <= 4'h0;
                        if (rw_reg)
                        begin
                            // The selector is left as it was, so reads may repeat freely.
                            tx_reg <= rd_byte; // RULE21
                            sda_oe <= !rd_byte[7];
                            state_reg <= ST_READ;
                        end
                        else
                        begin
                            sda_oe <= 1'b0;
                            state_reg <= ST_WRITE;
                        end
                    end
                end
                ST_WRITE:
                begin
                    if (scl_rise)
                    begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        bit_reg <= bit_reg + 4'h1;
                    end
                    else if (scl_fall && bit_reg == 4'h8)
                    begin
                        sda_oe <= 1'b1;
                        state_reg <= ST_ACK_WRITE;
                        if (!byte_idx_reg)
                        begin
                            selector_reg <= shift_reg; // RULE3
                            byte_idx_reg <= 1'b1;
                        end
                        else if (sel == `TS_SEL_CONFIG)
                            config_reg <= shift_reg; // RULE3 RULE22
                        else if (sel == `TS_SEL_UPPER)
                            upper_reg <= shift_reg; // RULE3 RULE22
                        else if (sel == `TS_SEL_LOWER)
                            lower_reg <= shift_reg; // RULE3 RULE22
                    end
                end
                ST_ACK_WRITE:
                begin
                    if (scl_fall)
                    begin
                        sda_oe <= 1'b0;
                        bit_reg <= 4'h0;
                        state_reg <= ST_WRITE;
                    end
                end
                ST_READ:
                begin
                    if (scl_fall)
                    begin
                        if (bit_reg == 4'h7)
                        begin
                            sda_oe <= 1'b0;
                            state_reg <= ST_MASTER_ACK;
                        end
                        else
                        begin
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            sda_oe <= !tx_reg[6];
                            bit_reg <= bit_reg + 4'h1;
                        end
                    end
                end
                ST_MASTER_ACK:
                begin
                    if (scl_rise)
                    begin
                        // A no-acknowledge ends the read; the slave idles until the next start.
                        if (sda_s)
                            state_reg <= ST_IDLE;
                        if (sel == `TS_SEL_RESULT)
                            second_half_reg <= !second_half_reg; // RULE11
                    end
                    else if (scl_fall)
                    begin
                        bit_reg <= 4'h0;
                        tx_reg <= rd_byte;
                        sda_oe <= !rd_byte[7];
                        state_reg <= ST_READ;
                    end
                end
                default:
                begin
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

endmodule // ts_sensor_regs

// ---- tb/ts_bus_master.sv ----
// Two-wire bus master model that drives the clock and pulls the data line low.
`timescale 1ns/1ps
module ts_bus_master
#(
    parameter HALF = 12
)
(
    input wire clk,
    input wire sda,
    output reg scl,
    output reg sda_low
);
    // The bus rests with the clock high and data released, so the clock stands between frames.
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Data moves well inside the low phase, since the slave sees both pins through a filter.
    task bit_xfer(input reg b, output reg r);
    begin
        repeat (3) @(posedge clk);
        sda_low <= !b;
        repeat (HALF - 3) @(posedge clk);
        scl <= 1'b1;
        repeat (HALF) @(posedge clk);
        r = sda;
        scl <= 1'b0;
    end
    endtask

    // A start is a data fall while the clock is high.
    task start_cond;
    begin
        @(posedge clk) sda_low <= 1'b1;
        repeat (HALF) @(posedge clk);
        scl <= 1'b0;
    end
    endtask

    // A stop is a data rise while the clock is high; the bus then idles.
    task stop_cond;
    begin
        repeat (3) @(posedge clk);
        sda_low <= 1'b1;
        repeat (HALF - 3) @(posedge clk);
        scl <= 1'b1;
        repeat (HALF) @(posedge clk);
        sda_low <= 1'b0;
        repeat (2 * HALF) @(posedge clk);
    end
    endtask

    // Eight bits out, most significant first, then the slave's acknowledge is read.
    task wr_byte(input [7:0] d, output reg nack);
        integer n;
        reg r;
    begin
        for (n = 7; n >= 0; n = n - 1)
            bit_xfer(d[n], r);
        bit_xfer(1'b1, nack);
    end
    endtask

    // Eight bits in, then the master acknowledges, or not on the last byte.
    task rd_byte(input reg last, output reg [7:0] d);
        integer n;
        reg r;
    begin
        for (n = 7; n >= 0; n = n - 1)
        begin
            bit_xfer(1'b1, r);
            d[n] = r;
        end
        bit_xfer(last, r);
    end
    endtask
endmodule // ts_bus_master

// ---- tb/ts_sensor_monitor.sv ----
// Port checker for the sensor register block.
`timescale 1ns/1ps
module ts_monitor
#(
    parameter WAIT_CYC = 50,
    parameter CONV_CYC = 10,
    parameter EXT_GRADE = 0
)
(
    input wire clk,
    input wire rst,
    input wire scl_in,
    input wire sda_out,
    input wire sda_oe,
    input wire alert_out,
    input wire alert_oe,
    input wire [9:0] adc_code,
    input wire conv_hold,
    input wire [11:0] temp_quarters
);
    reg [15:0] hi_cnt;
    reg [15:0] gap_cnt;
    reg [7:0] scl_cnt;

    // Conversion length, cycles since a conversion, and serial clock high time.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hi_cnt <= 16'h0000;
            gap_cnt <= 16'h0000;
            scl_cnt <= 8'h00;
        end
        else
        begin
            hi_cnt <= conv_hold ? hi_cnt + 16'h0001 : 16'h0000;
            gap_cnt <= conv_hold ? 16'h0000 : gap_cnt + 16'h0001;
            scl_cnt <= (scl_in && scl_cnt != 8'hFF) ? scl_cnt + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_reset_idle: assert property ($fell(rst) |-> !sda_oe && !conv_hold && !alert_oe)
        else $error("outputs not idle after reset");
    a_open_drain: assert property (sda_out == 1'b0 && alert_out == 1'b0)
        else $error("open drain pin value not low");
    a_conv_length: assert property ($fell(conv_hold) |-> hi_cnt == CONV_CYC)
        else $error("conversion length wrong");
    a_conv_spacing: assert property ($rose(conv_hold) |-> gap_cnt >= WAIT_CYC - 1)
        else $error("conversion started too early");
    a_temp_decode: assert property ($fell(conv_hold) && EXT_GRADE == 0 |->
        ##[1:3] temp_quarters == {{2{adc_code[9]}}, adc_code})
        else $error("decoded temperature wrong");
    a_temp_moment: assert property ($changed(temp_quarters) |-> gap_cnt < 16'h0004)
        else $error("temperature changed outside a conversion end");
    a_alert_cause: assert property ($changed(alert_oe) |-> gap_cnt < 16'h0004 || scl_cnt < 8'h14)
        else $error("alert changed without a cause");
    a_bus_release: assert property (scl_cnt >= 8'h14 |-> !sda_oe)
        else $error("data line held on an idle bus");
endmodule // ts_monitor

bind ts_sensor_regs ts_monitor #(.WAIT_CYC(WAIT_CYC), .CONV_CYC(CONV_CYC), .EXT_GRADE(EXT_GRADE))
    u_mon (.clk(clk), .rst(rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .alert_out(alert_out), .alert_oe(alert_oe), .adc_code(adc_code), .conv_hold(conv_hold),
    .temp_quarters(temp_quarters));

// ---- tb/tb_top.sv ----
// Self-checking bench for the sensor register block.
`timescale 1ns/1ps
`include "ts_map.vh"
module tb_top;
    localparam WAIT_CYC = 50;
    localparam CONV_CYC = 10;
    localparam [31:0] CFG_TAB = 32'h0010_3020;
    reg clk;
    reg rst;
    reg [9:0] adc_code;
    wire scl;
    wire sda_low;
    wire sda;
    wire sda_out;
    wire sda_oe;
    wire alert_out;
    wire alert_oe;
    wire conv_hold;
    wire [11:0] temp_quarters;
    wire [11:0] ext_quarters;
    integer n_fail;
    integer num_checks;
    integer i;
    integer k;
    reg nack;
    reg [7:0] b0;
    reg [7:0] b1;

    // Open-drain data wire: pulled up unless a party pulls it low.
    assign sda = !sda_low && (sda_oe ? sda_out : 1'b1);

    ts_bus_master #(.HALF(12)) mst (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

    ts_sensor_regs #(.WAIT_CYC(WAIT_CYC), .CONV_CYC(CONV_CYC)) uut (.clk(clk), .rst(rst),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .alert_out(alert_out),
        .alert_oe(alert_oe), .adc_code(adc_code), .conv_hold(conv_hold),
        .temp_quarters(temp_quarters));

    // Second copy in the extended grade, bus left idle, so the other decode is checked.
    ts_sensor_regs #(.WAIT_CYC(WAIT_CYC), .CONV_CYC(CONV_CYC), .EXT_GRADE(1)) uut_ext
        (.clk(clk), .rst(rst), .scl_in(1'b1), .sda_in(1'b1), .sda_out(), .sda_oe(),
        .alert_out(), .alert_oe(), .adc_code(adc_code), .conv_hold(),
        .temp_quarters(ext_quarters));

    // Free-running 50 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task chk(input [11:0] got, input [11:0] exp);
    begin
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    task results;
    begin
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask

    // Address, selector, then at most one data byte; a foreign address must go unanswered.
    task reg_wr(input [6:0] addr, input [7:0] sel, input [7:0] data, input reg with_data);
    begin
        mst.start_cond;
        mst.wr_byte({addr, 1'b0}, nack);
        chk(nack, addr != `TS_BUS_ADDR);
        if (!nack)
            mst.wr_byte(sel, nack);
        if (!nack && with_data)
            mst.wr_byte(data, nack);
        mst.stop_cond;
    end
    endtask

    // Read one byte, or two with the first acknowledged.
    task reg_rd(input reg two);
    begin
        mst.start_cond;
        mst.wr_byte({`TS_BUS_ADDR, 1'b1}, nack);
        mst.rd_byte(!two, b0);
        if (two)
            mst.rd_byte(1'b1, b1);
        mst.stop_cond;
    end
    endtask

    task read_temp(input [7:0] e0, input [7:0] e1);
    begin
        reg_rd(1'b1);
        chk(b0, e0);
        chk(b1, e1);
    end
    endtask

    // Waits for the end of the next conversion; a missing one is a mismatch.
    task wait_conv;
    begin
        for (k = 0; k < 400 && conv_hold !== 1'b1; k = k + 1)
            @(posedge clk);
        for (i = 0; i < 40 && conv_hold !== 1'b0; i = i + 1)
            @(posedge clk);
        repeat (4) @(posedge clk);
        chk(k < 400 && i < 40, 1'b1);
    end
    endtask

    // Changes the code just after a conversion starts, so that it is steady at the result
    // load and for several cycles after it, then waits for that conversion to end.
    task set_code(input [9:0] c);
    begin
        while (conv_hold !== 1'b0)
            @(posedge clk);
        while (conv_hold !== 1'b1)
            @(posedge clk);
        adc_code <= c;
        wait_conv;
    end
    endtask

    // Bounds the run in case the bus or the timebase hangs.
    initial
    begin
        #1_500_000;
        n_fail = n_fail + 1;
        results;
    end

    initial
    begin
        n_fail = 0;
        num_checks = 0;
        rst = 1'b1;
        adc_code = 10'h000;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        chk(alert_oe, 1'b0);
        reg_wr(`TS_BUS_ADDR, 8'h01, 8'h00, 1'b0);
        reg_rd(1'b0);
        chk(b0, 8'h40);
        reg_rd(1'b0);
        chk(b0, 8'h40);
        reg_wr(7'h49, 8'h01, 8'h00, 1'b1);
        $display("test reset done");
        // Limits of 25 and 20 degrees; upper selector bits must not matter.
        reg_wr(`TS_BUS_ADDR, 8'h02, 8'h19, 1'b1);
        reg_wr(`TS_BUS_ADDR, 8'h03, 8'h14, 1'b1);
        reg_rd(1'b0);
        chk(b0, 8'h14);
        reg_wr(`TS_BUS_ADDR, 8'hFE, 8'h00, 1'b0);
        reg_rd(1'b0);
        chk(b0, 8'h19);
        reg_wr(`TS_BUS_ADDR, 8'h00, 8'hAA, 1'b1);
        reg_rd(1'b1);
        chk(b0, 8'h00);
        $display("test limits done");
        // Above the upper limit, between the limits, then below the lower limit.
        // A two-byte read first clears flags that older codes may have left set.
        set_code(10'h06B);
        chk(temp_quarters, 12'h06B);
        chk(ext_quarters, 12'h0CF);
        chk(alert_oe, 1'b1);
        reg_rd(1'b1);
        read_temp(8'h1A, 8'hD0);
        set_code(10'h059);
        reg_rd(1'b1);
        read_temp(8'h16, 8'h40);
        chk(alert_oe, 1'b1);
        set_code(10'h3FA);
        chk(temp_quarters, 12'hFFA);
        chk(ext_quarters, 12'h05E);
        chk(alert_oe, 1'b0);
        read_temp(8'hFE, 8'hA8);
        wait_conv;
        read_temp(8'hFE, 8'hA8);
        $display("test flags done");
        // Polarity and disable with the alert condition active, filter bypassed.
        set_code(10'h06B);
        for (i = 0; i < 4; i = i + 1)
        begin
            reg_wr(`TS_BUS_ADDR, 8'h01, CFG_TAB[31 - 8 * i -: 8], 1'b1);
            chk(alert_oe, !i[0]);
            reg_rd(1'b0);
            chk(b0, CFG_TAB[31 - 8 * i -: 8]);
        end
        $display("test config done");
        // Power-down stops conversions; clearing it brings them back.
        reg_wr(`TS_BUS_ADDR, 8'h01, 8'hC0, 1'b1);
        repeat (2 * CONV_CYC) @(posedge clk);
        for (k = 0; k < WAIT_CYC + 200 && conv_hold !== 1'b1; k = k + 1)
            @(posedge clk);
        chk(conv_hold, 1'b0);
        reg_wr(`TS_BUS_ADDR, 8'h01, 8'h40, 1'b1);
        wait_conv;
        $display("test power done");
        results;
    end
endmodule // tb_top
